//--- loop_pkg.sv
/*
 * shared constants and types for the loopback format selector.
 * assumes one clock domain and same-clock command sources.
 */
package loop_pkg;
    localparam int DATA_BITS = 512;
    localparam int LEN_W = 16;
    localparam int CRC_BITS = 24;
    localparam int FMT_W = 4;
    localparam int NUM_FMT = 3;
    localparam logic MODE_ONE = 1'h0;
    localparam logic MODE_TWO = 1'h1;
    localparam logic [LEN_W-1:0] SIZE_ZERO = 16'h0000;

    typedef enum logic [0:0] {
        LOOP_OPEN,
        LOOP_CLOSED
    } loop_state_t;
endpackage : loop_pkg

//--- skid_buffer.sv
/*
 * two-entry skid buffer, valid/ready on both sides, all outputs from flops.
 * assumes the consumer may hold out_ready_i low for any number of cycles.
 */
`timescale 1ns/1ps
module skid_buffer #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    logic out_valid_ff, nxt_out_valid;
    logic skid_valid_ff, nxt_skid_valid;
    logic ready_ff, nxt_ready;
    logic [W-1:0] out_data_ff, nxt_out_data;
    logic [W-1:0] skid_data_ff, nxt_skid_data;
    logic drain;
    logic push;

    generate
        if (W < 1) begin : g_bad_width
            $error("skid_buffer width must be positive");
        end
    endgenerate

    always_comb begin
        drain = out_ready_i | ~out_valid_ff;
        push = in_valid_i & ~skid_valid_ff;
        nxt_out_valid = out_valid_ff;
        nxt_out_data = out_data_ff;
        nxt_skid_valid = skid_valid_ff;
        nxt_skid_data = skid_data_ff;
        if (drain) begin
            if (skid_valid_ff) begin
                nxt_out_valid = 1'h1;
                nxt_out_data = skid_data_ff;
                nxt_skid_valid = 1'h0;
            end else begin
                nxt_out_valid = push;
                if (push) begin
                    nxt_out_data = in_data_i;
                end
            end
        end else if (push) begin
            // output stalled: park the word instead of losing it
            nxt_skid_valid = 1'h1;
            nxt_skid_data = in_data_i;
        end
        // ready from its own flop, so no gate sits on the upstream path
        nxt_ready = ~nxt_skid_valid;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_valid_ff <= 1'h0;
            skid_valid_ff <= 1'h0;
            ready_ff <= 1'h1;
            out_data_ff <= '0;
            skid_data_ff <= '0;
        end else begin
            out_valid_ff <= nxt_out_valid;
            skid_valid_ff <= nxt_skid_valid;
            ready_ff <= nxt_ready;
            out_data_ff <= nxt_out_data;
            skid_data_ff <= nxt_skid_data;
        end
    end

    assign in_ready_o = ready_ff;
    assign out_valid_o = out_valid_ff;
    assign out_data_o = out_data_ff;
endmodule : skid_buffer

//--- loopback_format_selector.sv
/*
 * terminal-side loopback for the second loop mode: returns each downlink
 * block plus its crc in the smallest fitting uplink format, cut to the largest one when none fits.
 * assumes commands and format sizes come from same-clock logic.
 */
`timescale 1ns/1ps
// Operation
// - in second loop mode, return downlink block followed by its crc bits.
// - pick smallest configured uplink format holding block plus crc.
// - if nothing fits, use largest format and drop trailing bits.
// - answer close command with close ack; data follows the ack.
module loopback_format_selector #(
    parameter int NUM_FMT = loop_pkg::NUM_FMT,
    parameter int DATA_BITS = loop_pkg::DATA_BITS,
    parameter int CRC_BITS = loop_pkg::CRC_BITS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic close_loop_command_i,
    input wire logic close_mode_i,
    input wire logic open_loop_command_i,
    output logic close_loop_ack_o,
    output logic loop_closed_o,
    output logic loop_mode_o,
    input wire logic [NUM_FMT*loop_pkg::LEN_W-1:0] fmt_size_i,
    input wire logic dl_valid_i,
    output logic dl_ready_o,
    input wire logic [DATA_BITS-1:0] dl_data_i,
    input wire logic [loop_pkg::LEN_W-1:0] dl_len_i,
    input wire logic [CRC_BITS-1:0] dl_crc_i,
    input wire logic [loop_pkg::LEN_W-1:0] dl_crc_len_i,
    output logic ul_valid_o,
    input wire logic ul_ready_i,
    output logic [DATA_BITS-1:0] ul_data_o,
    output logic [loop_pkg::LEN_W-1:0] ul_size_o,
    output logic [loop_pkg::FMT_W-1:0] format_indicator_o,
    output logic ul_truncated_o
);
    localparam int LW = loop_pkg::LEN_W;
    localparam int FW = loop_pkg::FMT_W;
    localparam int SW = LW + 1;
    localparam int BW = 1 + FW + LW + DATA_BITS;

    generate
        if (NUM_FMT < 1 || NUM_FMT > (1 << FW) || CRC_BITS > DATA_BITS)
        begin : g_bad_params
            $error("unsupported format count or crc width");
        end
    endgenerate

    function automatic logic [LW-1:0] size_of(
        input logic [NUM_FMT*LW-1:0] vec,
        input int idx
    );
        size_of = vec[idx*LW +: LW];
    endfunction : size_of

    loop_pkg::loop_state_t state_ff, nxt_state;
    logic mode_ff, nxt_mode;
    logic ack_ff, nxt_ack;
    logic active;

    always_comb begin
        nxt_state = state_ff;
        nxt_mode = mode_ff;
        nxt_ack = 1'h0;
        case (state_ff)
            loop_pkg::LOOP_OPEN: begin
                if (close_loop_command_i) begin
                    nxt_state = loop_pkg::LOOP_CLOSED;
                    nxt_mode = close_mode_i;
                    nxt_ack = 1'h1;
                end
            end
            loop_pkg::LOOP_CLOSED: begin
                if (close_loop_command_i) begin
                    // a repeated close re-acks and may change the mode
                    nxt_mode = close_mode_i;
                    nxt_ack = 1'h1;
                end else if (open_loop_command_i) begin
                    nxt_state = loop_pkg::LOOP_OPEN;
                end
            end
            default: begin
                nxt_state = loop_pkg::LOOP_OPEN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= loop_pkg::LOOP_OPEN;
            mode_ff <= loop_pkg::MODE_ONE;
            ack_ff <= 1'h0;
        end else begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode;
            ack_ff <= nxt_ack;
        end
    end

    // only mode two framing lives here; mode one words are dropped
    assign active = (state_ff == loop_pkg::LOOP_CLOSED) &&
                    (mode_ff == loop_pkg::MODE_TWO);

    logic [SW-1:0] need;
    logic [LW-1:0] sel_size;
    logic [FW-1:0] sel_idx;
    logic sel_fit;
    logic exact_exists;
    logic [LW-1:0] max_size;

    always_comb begin
        logic [LW-1:0] best_size;
        logic [FW-1:0] best_idx;
        logic found;
        logic [FW-1:0] max_idx;
        best_size = loop_pkg::SIZE_ZERO;
        best_idx = '0;
        found = 1'h0;
        max_size = size_of(fmt_size_i, 0);
        max_idx = '0;
        exact_exists = 1'h0;
        need = {1'h0, dl_len_i} + {1'h0, dl_crc_len_i};
        for (int i = 0; i < NUM_FMT; i++) begin
            // equal size fits; ties keep the lower index
            if ({1'h0, size_of(fmt_size_i, i)} >= need &&
                (!found || size_of(fmt_size_i, i) < best_size)) begin
                found = 1'h1;
                best_size = size_of(fmt_size_i, i);
                best_idx = FW'(i);
            end
            if ({1'h0, size_of(fmt_size_i, i)} == need) begin
                exact_exists = 1'h1;
            end
            if (size_of(fmt_size_i, i) > max_size) begin
                max_size = size_of(fmt_size_i, i);
                max_idx = FW'(i);
            end
        end
        sel_fit = found;
        sel_size = found ? best_size : max_size;
        sel_idx = found ? best_idx : max_idx;
    end

    logic [DATA_BITS-1:0] len_mask;
    logic [DATA_BITS-1:0] size_mask;
    logic [CRC_BITS-1:0] crc_mask;
    logic [DATA_BITS-1:0] ul_word;

    always_comb begin
        len_mask = ~({DATA_BITS{1'h1}} << dl_len_i);
        size_mask = ~({DATA_BITS{1'h1}} << sel_size);
        crc_mask = ~({CRC_BITS{1'h1}} << dl_crc_len_i);
        // block in the low bits, crc right after it, cut at format size
        ul_word = ((dl_data_i & len_mask) |
                   (DATA_BITS'(dl_crc_i & crc_mask) << dl_len_i))
                  & size_mask;
    end

    logic buf_ready;
    logic push;
    logic [BW-1:0] buf_out;

    assign push = dl_valid_i & active & buf_ready;

    skid_buffer #(
        .W(BW)
    ) u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(dl_valid_i & active),
        .in_ready_o(buf_ready),
        .in_data_i({~sel_fit, sel_idx, sel_size, ul_word}),
        .out_valid_o(ul_valid_o),
        .out_ready_i(ul_ready_i),
        .out_data_o(buf_out)
    );

    assign dl_ready_o = buf_ready;
    assign ul_data_o = buf_out[DATA_BITS-1:0];
    assign ul_size_o = buf_out[DATA_BITS +: LW];
    assign format_indicator_o = buf_out[DATA_BITS+LW +: FW];
    assign ul_truncated_o = buf_out[BW-1];
    assign close_loop_ack_o = ack_ff;
    assign loop_closed_o = (state_ff == loop_pkg::LOOP_CLOSED);
    assign loop_mode_o = mode_ff;

    logic smaller_exists;
    always_comb begin
        smaller_exists = 1'h0;
        for (int i = 0; i < NUM_FMT; i++) begin
            if ({1'h0, size_of(fmt_size_i, i)} >= need &&
                size_of(fmt_size_i, i) < sel_size) begin
                smaller_exists = 1'h1;
            end
        end
    end

    fit_ok_a: assert property (@(posedge clk_i) disable iff (rst_i)
        push && sel_fit |-> {1'h0, sel_size} >= need && !smaller_exists)
        else $error("chosen format is not the smallest fitting one");
    exact_fit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        push && exact_exists |-> {1'h0, sel_size} == need)
        else $error("exact fitting format not chosen");
    trunc_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
        push && {1'h0, max_size} < need |-> !sel_fit && sel_size == max_size)
        else $error("oversize block did not take largest format");
    payload_a: assert property (@(posedge clk_i) disable iff (rst_i)
        push |-> (ul_word & len_mask & size_mask) ==
                 (dl_data_i & len_mask & size_mask) &&
                 (ul_word & ~size_mask) == '0)
        else $error("block bits not placed first or not cut at size");
    close_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        close_loop_command_i |=> close_loop_ack_o && loop_closed_o)
        else $error("close command not acknowledged next cycle");
    ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        close_loop_ack_o |-> $past(close_loop_command_i))
        else $error("close ack without close command");
    open_loop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        open_loop_command_i && !close_loop_command_i |=> !loop_closed_o)
        else $error("open command did not leave loopback");
    fmt_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ul_valid_o && !ul_ready_i |=> ul_valid_o &&
            $stable(format_indicator_o) && $stable(ul_data_o) &&
            $stable(ul_size_o))
        else $error("outgoing block or index changed while stalled");
    idle_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !active && !ul_valid_o && dl_ready_o |=> !ul_valid_o)
        else $error("block returned while loop not in mode two");

    exact_c: cover property (@(posedge clk_i) disable iff (rst_i)
        push && exact_exists);
    trunc_c: cover property (@(posedge clk_i) disable iff (rst_i)
        push && !sel_fit);
    stall_c: cover property (@(posedge clk_i) disable iff (rst_i)
        ul_valid_o && !ul_ready_i && !dl_ready_o);
    close_c: cover property (@(posedge clk_i) disable iff (rst_i)
        close_loop_ack_o ##[1:20] push);
endmodule : loopback_format_selector

//--- far_end_model.sv
/*
 * far-end model: takes uplink blocks in order, can stall on request.
 * assumes the bench drives commands and downlink blocks in its place.
 */
`timescale 1ns/1ps
module far_end_model (
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic ul_valid_i,
    output logic ul_ready_o,
    input wire logic [511:0] ul_data_i,
    input wire logic [15:0] ul_size_i,
    input wire logic [3:0] fmt_i,
    input wire logic trunc_i
);
    logic rdy_ff = 1'h0;
    logic [532:0] got_q[$];
    assign ul_ready_o = rdy_ff;
    // ready registered, so a stall lands one edge late, like a real sink
    always @(posedge clk_i) begin
        rdy_ff <= !stall_i;
        if (ul_valid_i && rdy_ff) begin
            // indicator kept for judging against the format sent
            got_q.push_back({trunc_i, fmt_i, ul_size_i, ul_data_i});
        end
    end
endmodule : far_end_model

//--- loopback_format_selector_bench.sv
/*
 * bench for the loopback format selector; the bench plays the far side.
 * assumes loop_pkg, skid_buffer and far_end_model are compiled first.
 */
`timescale 1ns/1ps
module loopback_format_selector_bench;
    localparam logic [511:0] PAT = {16{32'hC3A5_5A3C}};
    localparam logic [23:0] CRC = 24'hB4C2E1;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic close_c = 1'h0, close_m = 1'h0, open_c = 1'h0, stall = 1'h0;
    logic dl_valid = 1'h0;
    logic ack, closed, mode, dl_ready, ul_valid, ul_ready, trunc;
    logic [47:0] sizes = 48'h0;
    logic [511:0] dl_data = 512'h0, ul_data;
    logic [15:0] dl_len = 16'h0, crc_len = 16'h0, ul_size;
    logic [3:0] fmt;
    int bad_count = 0, checks = 0, cycles = 0;

    loopback_format_selector loopback_format_selector_inst (
        .clk_i(clk_i), .rst_i(rst_i), .close_loop_command_i(close_c),
        .close_mode_i(close_m), .open_loop_command_i(open_c),
        .close_loop_ack_o(ack), .loop_closed_o(closed), .loop_mode_o(mode),
        .fmt_size_i(sizes), .dl_valid_i(dl_valid), .dl_ready_o(dl_ready),
        .dl_data_i(dl_data), .dl_len_i(dl_len), .dl_crc_i(CRC),
        .dl_crc_len_i(crc_len), .ul_valid_o(ul_valid), .ul_ready_i(ul_ready),
        .ul_data_o(ul_data), .ul_size_o(ul_size),
        .format_indicator_o(fmt), .ul_truncated_o(trunc));
    far_end_model far_end_model_inst (
        .clk_i(clk_i), .stall_i(stall), .ul_valid_i(ul_valid),
        .ul_ready_o(ul_ready), .ul_data_i(ul_data), .ul_size_i(ul_size),
        .fmt_i(fmt), .trunc_i(trunc));

    initial forever #2 clk_i = ~clk_i;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic check(input logic [511:0] seen, input logic [511:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %0h want %0h", $time, seen,
                exp);
        end
    endtask : check

    function automatic logic [511:0] looped(input int len, input int cl,
            input int size);
        logic [511:0] r;
        r = 512'h0;
        for (int i = 0; i < size; i++) begin
            if (i < len) r[i] = PAT[i] ^ 1'(i < 16 && len[i]);
            else if (i < len + cl) r[i] = CRC[i - len];
        end
        return r;
    endfunction : looped

    // caller lowers dl_valid, so back-to-back sends keep it high
    task automatic send(input int len, input int cl);
        logic ok;
        dl_valid <= 1'h1;
        dl_len <= 16'(len);
        crc_len <= 16'(cl);
        dl_data <= PAT ^ 512'(16'(len));
        do begin
            @(negedge clk_i);
            ok = dl_ready;
            @(posedge clk_i);
        end while (!ok);
    endtask : send

    task automatic expect_ul(input int len, input int cl, input int idx,
            input logic tr);
        logic [532:0] g;
        int size;
        size = int'(sizes[idx*16 +: 16]);
        for (int n = 0; n < 50 && far_end_model_inst.got_q.size() == 0; n++)
            @(posedge clk_i);
        if (far_end_model_inst.got_q.size() == 0) begin
            check(512'h0, 512'h1);
        end else begin
            g = far_end_model_inst.got_q.pop_front();
            check(g[511:0], looped(len, cl, size));
            check(512'(g[527:512]), 512'(size));
            check(512'(g[531:528]), 512'(idx));
            check(512'(g[532]), 512'(tr));
        end
    endtask : expect_ul

    task automatic close_loop(input logic m);
        close_c <= 1'h1;
        close_m <= m;
        @(posedge clk_i);
        close_c <= 1'h0;
        @(negedge clk_i);
        check(512'({ack, closed, mode}), 512'({2'h3, m}));
        @(negedge clk_i);
        check(512'(ack), 512'h0);
        @(posedge clk_i);
    endtask : close_loop

    task automatic open_loop();
        open_c <= 1'h1;
        @(posedge clk_i);
        open_c <= 1'h0;
        @(negedge clk_i);
        check(512'(closed), 512'h0);
        @(posedge clk_i);
    endtask : open_loop

    task automatic one_block(input int len, input int cl, input int idx,
            input logic tr);
        send(len, cl);
        dl_valid <= 1'h0;
        expect_ul(len, cl, idx, tr);
        @(posedge clk_i);
    endtask : one_block

    task automatic scen_formats();
        close_loop(1'h1);
        sizes <= 48'h006F_0037_0000;
        @(posedge clk_i);
        one_block(39, 16, 1, 1'h0);
        one_block(40, 16, 2, 1'h0);
        one_block(95, 16, 2, 1'h0);
        one_block(96, 16, 2, 1'h1);
        one_block(0, 0, 0, 1'h0);
    endtask : scen_formats

    task automatic scen_detect();
        sizes <= 48'h0073_006B_0033;
        @(posedge clk_i);
        one_block(95, 12, 1, 1'h0);
        one_block(39, 12, 0, 1'h0);
        one_block(103, 12, 2, 1'h0);
    endtask : scen_detect

    // two blocks parked while the far side stalls, none may be lost
    task automatic scen_stall();
        stall <= 1'h1;
        send(20, 8);
        send(30, 8);
        dl_valid <= 1'h0;
        repeat (3) @(negedge clk_i);
        check(512'(dl_ready), 512'h0);
        @(posedge clk_i);
        stall <= 1'h0;
        expect_ul(20, 8, 0, 1'h0);
        expect_ul(30, 8, 0, 1'h0);
        @(posedge clk_i);
    endtask : scen_stall

    // mode one looping is absent, so nothing may come back
    task automatic scen_mode_one();
        close_loop(1'h0);
        send(39, 12);
        dl_valid <= 1'h0;
        repeat (10) @(posedge clk_i);
        check(512'(far_end_model_inst.got_q.size()), 512'h0);
        open_loop();
        open_loop();
        // loop open: a block is taken and dropped
        send(39, 12);
        dl_valid <= 1'h0;
        repeat (10) @(posedge clk_i);
        check(512'(far_end_model_inst.got_q.size()), 512'h0);
        close_loop(1'h1);
        close_loop(1'h1);
        one_block(39, 12, 0, 1'h0);
    endtask : scen_mode_one

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        @(negedge clk_i);
        check(512'({dl_ready, ul_valid, closed, ack}), 512'h8);
        @(posedge clk_i);
        scen_formats();
        scen_detect();
        scen_stall();
        scen_mode_one();
        report_and_stop();
    end
endmodule : loopback_format_selector_bench
